// >>> rtl/physical_address_decoder.sv
// physical address decoder: internal windows, external i/o selects, dram banks
//
// Function
// - 0x0F000000-0x0F00001F selects bus control unit window.
// - 0x0F000020-0x0F00003F selects first dma address unit window.
// - 0x0F000040-0x0F00005F selects dma control unit window.
// - 0x0F000060-0x0F00007F selects clock mask unit window.
// - interrupt control windows at 0x0F000080 and 0x0F0000A0, 32 bytes each.
// - power management windows at 0x0F0000C0 and 0x0F0000E0, 32 bytes each.
// - timekeeping windows at 0x0F000100 and 0x0F000120, 32 bytes each.
// - general i/o windows at 0x0F000140 and 0x0F000160, 32 bytes each.
// - 0x0F000180-0x0F00019F selects led control unit window.
// - clocked serial windows at 0x0F0001A0 and 0x0F0001C0, 32 bytes each.
// - 0x0F0001E0-0x0F0001FF selects second dma address unit window.
// - 0x0F000400-0x0F00041F selects sdram control unit window.
// - serial port at 0x0F000800, debug serial port at 0x0F000820.
// - fast infrared windows at 0x0F000840 and 0x0F000860, 32 bytes each.
// - pci bridge 0x0F000C00-0x0F000DFF, system control 0x0F001000-0x0F00101F.
// - reserved internal gaps select no peripheral.
// - ext select 1 for 0x0C000000-0x0DFFFFFF, select 0 for 0x0A000000-0x0BFFFFFF.
// - four dram banks; wide bus puts banks 2 and 3 in expansion space.
// - wide bus strap: 0 is 16-bit mode, 1 is 32-bit mode.
// - capacity codes 2,3,4,5 mean 8,16,32,64 MB.
// - banks stacked contiguously upward from address 0, bank 0 first.
`timescale 1ns/1ps

module physical_address_decoder (
   input wire logic clk,
   input wire logic srst,
   // processor side
   input wire logic addr_valid,
   input wire logic [31:0] phys_addr,
   input wire logic wide_bus_strap,
   // internal windows
   output logic bus_control_unit_sel,
   output logic dma_address_unit_1_sel,
   output logic dma_control_unit_sel,
   output logic clock_mask_unit_sel,
   output logic interrupt_control_unit_1_sel,
   output logic interrupt_control_unit_2_sel,
   output logic power_mgmt_unit_1_sel,
   output logic power_mgmt_unit_2_sel,
   output logic timekeeping_unit_1_sel,
   output logic timekeeping_unit_2_sel,
   output logic general_io_unit_1_sel,
   output logic general_io_unit_2_sel,
   output logic led_control_unit_sel,
   output logic clocked_serial_unit_1_sel,
   output logic clocked_serial_unit_2_sel,
   output logic dma_address_unit_2_sel,
   output logic sdram_control_unit_sel,
   output logic serial_port_unit_sel,
   output logic debug_serial_unit_sel,
   output logic fast_infrared_unit_1_sel,
   output logic fast_infrared_unit_2_sel,
   output logic pci_bridge_unit_sel,
   output logic system_control_unit_sel,
   // external i/o and dram
   output logic ext_io_select_0,
   output logic ext_io_select_1,
   output logic dram_bank_select_0,
   output logic dram_bank_select_1,
   output logic dram_rom_bank_select_2,
   output logic dram_rom_bank_select_3,
   output logic dram_expansion_space,
   output logic wide_bus_mode,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);

   // every check below runs on the one system clock
   default clocking main_cb @(posedge clk);
   endclocking
   default disable iff (srst);

   // ************************************************
   // helpers
   // ************************************************
   function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   // invalid codes give an empty bank so a bad setting never aliases another bank
   function automatic logic [31:0] cap_bytes(input logic [2:0] code);
      case (code)
         addr_decode_pkg::CODE_8MB: cap_bytes = addr_decode_pkg::CAP_8MB;
         addr_decode_pkg::CODE_16MB: cap_bytes = addr_decode_pkg::CAP_16MB;
         addr_decode_pkg::CODE_32MB: cap_bytes = addr_decode_pkg::CAP_32MB;
         addr_decode_pkg::CODE_64MB: cap_bytes = addr_decode_pkg::CAP_64MB;
         default: cap_bytes = 32'h0000_0000;
      endcase
   endfunction

   // ************************************************
   // strap synchroniser
   // ************************************************
   logic strap_meta_ff;
   logic strap_sync_ff;

   always_ff @(posedge clk) begin
      if (srst) begin
         strap_meta_ff <= 1'b0;
         strap_sync_ff <= 1'b0;
      end else begin
         strap_meta_ff <= wide_bus_strap;
         strap_sync_ff <= strap_meta_ff;
      end
   end

   assign wide_bus_mode = strap_sync_ff;

   // ************************************************
   // memory size register
   // ************************************************
   logic [2:0] code0_ff;
   logic [2:0] code1_ff;
   logic [2:0] code2_ff;
   logic [2:0] code3_ff;
   logic wr_acc;

   // a write lands only at the access edge, never in setup
   assign wr_acc = psel && penable && pwrite;

   always_ff @(posedge clk) begin
      if (srst) begin
         code0_ff <= addr_decode_pkg::CODE_RESET;
         code1_ff <= addr_decode_pkg::CODE_RESET;
         code2_ff <= addr_decode_pkg::CODE_RESET;
         code3_ff <= addr_decode_pkg::CODE_RESET;
      end else if (wr_acc && paddr == addr_decode_pkg::OFS_MEM_SIZE) begin
         code0_ff <= pwdata[addr_decode_pkg::CODE0_POS +: 3];
         code1_ff <= pwdata[addr_decode_pkg::CODE1_POS +: 3];
         code2_ff <= pwdata[addr_decode_pkg::CODE2_POS +: 3];
         code3_ff <= pwdata[addr_decode_pkg::CODE3_POS +: 3];
      end
   end

   // ************************************************
   // internal and external i/o decode
   // ************************************************
   logic [addr_decode_pkg::NUM_WIN-1:0] win_hit;
   logic int_hit;
   logic ext1_hit;
   logic ext0_hit;

   always_comb begin
      for (int i = 0; i < addr_decode_pkg::NUM_WIN; i++) begin
         // gaps fall through every window and match nothing
         win_hit[i] = addr_valid && in_range(phys_addr, addr_decode_pkg::WIN_LO[i],
                                             addr_decode_pkg::WIN_HI[i]);
      end
   end

   // windows are disjoint, so at most one win_hit bit is high
   assign int_hit = |win_hit;
   assign ext1_hit = addr_valid && in_range(phys_addr, addr_decode_pkg::EXT_IO1_LO, addr_decode_pkg::EXT_IO1_HI);
   assign ext0_hit = addr_valid && in_range(phys_addr, addr_decode_pkg::EXT_IO0_LO, addr_decode_pkg::EXT_IO0_HI);

   assign bus_control_unit_sel = win_hit[addr_decode_pkg::IDX_BUS_CTRL];
   assign dma_address_unit_1_sel = win_hit[addr_decode_pkg::IDX_DMA_ADDR1];
   assign dma_control_unit_sel = win_hit[addr_decode_pkg::IDX_DMA_CTRL];
   assign clock_mask_unit_sel = win_hit[addr_decode_pkg::IDX_CLK_MASK];
   assign interrupt_control_unit_1_sel = win_hit[addr_decode_pkg::IDX_INT_CTRL1];
   assign interrupt_control_unit_2_sel = win_hit[addr_decode_pkg::IDX_INT_CTRL2];
   assign power_mgmt_unit_1_sel = win_hit[addr_decode_pkg::IDX_PWR1];
   assign power_mgmt_unit_2_sel = win_hit[addr_decode_pkg::IDX_PWR2];
   assign timekeeping_unit_1_sel = win_hit[addr_decode_pkg::IDX_TIME1];
   assign timekeeping_unit_2_sel = win_hit[addr_decode_pkg::IDX_TIME2];
   assign general_io_unit_1_sel = win_hit[addr_decode_pkg::IDX_GPIO1];
   assign general_io_unit_2_sel = win_hit[addr_decode_pkg::IDX_GPIO2];
   assign led_control_unit_sel = win_hit[addr_decode_pkg::IDX_LED];
   assign clocked_serial_unit_1_sel = win_hit[addr_decode_pkg::IDX_CSER1];
   assign clocked_serial_unit_2_sel = win_hit[addr_decode_pkg::IDX_CSER2];
   assign dma_address_unit_2_sel = win_hit[addr_decode_pkg::IDX_DMA_ADDR2];
   assign sdram_control_unit_sel = win_hit[addr_decode_pkg::IDX_SDRAM];
   assign serial_port_unit_sel = win_hit[addr_decode_pkg::IDX_SERIAL];
   assign debug_serial_unit_sel = win_hit[addr_decode_pkg::IDX_DBG_SERIAL];
   assign fast_infrared_unit_1_sel = win_hit[addr_decode_pkg::IDX_IR1];
   assign fast_infrared_unit_2_sel = win_hit[addr_decode_pkg::IDX_IR2];
   assign pci_bridge_unit_sel = win_hit[addr_decode_pkg::IDX_PCI];
   assign system_control_unit_sel = win_hit[addr_decode_pkg::IDX_SYS_CTRL];
   assign ext_io_select_1 = ext1_hit;
   assign ext_io_select_0 = ext0_hit;

   // ************************************************
   // dram bank decode
   // ************************************************
   // four 64 MB banks reach into i/o space; i/o windows win there so one select stays
   logic [31:0] bank_end0;
   logic [31:0] bank_end1;
   logic [31:0] bank_end2;
   logic [31:0] bank_end3;
   logic dram_ok;
   // the top reaches 256 MB at most, so the running sums cannot wrap

   always_comb begin
      bank_end0 = addr_decode_pkg::DRAM_BASE + cap_bytes(code0_ff);
      bank_end1 = bank_end0 + cap_bytes(code1_ff);
      bank_end2 = bank_end1 + cap_bytes(code2_ff);
      bank_end3 = bank_end2 + cap_bytes(code3_ff);
   end

   assign dram_ok = addr_valid && !int_hit && !ext1_hit && !ext0_hit &&
                    !in_range(phys_addr, addr_decode_pkg::INT_IO_LO, addr_decode_pkg::INT_IO_HI);
   assign dram_bank_select_0 = dram_ok && phys_addr < bank_end0;
   assign dram_bank_select_1 = dram_ok && phys_addr >= bank_end0 && phys_addr < bank_end1;
   assign dram_rom_bank_select_2 = dram_ok && phys_addr >= bank_end1 && phys_addr < bank_end2;
   assign dram_rom_bank_select_3 = dram_ok && phys_addr >= bank_end2 && phys_addr < bank_end3;
   assign dram_expansion_space = strap_sync_ff && (dram_rom_bank_select_2 || dram_rom_bank_select_3);

   // ************************************************
   // apb read side
   // ************************************************
   logic codes_ordered;
   logic [31:0] nxt_prdata;
   logic [31:0] prdata_ff;
   logic mapped;

   // high while the codes keep the non-increasing order software must keep
   assign codes_ordered = (code0_ff >= code1_ff) && (code1_ff >= code2_ff) && (code2_ff >= code3_ff);

   always_comb begin
      nxt_prdata = 32'h0000_0000;
      mapped = 1'b1;
      case (paddr)
         addr_decode_pkg::OFS_MEM_SIZE: begin
            nxt_prdata[addr_decode_pkg::CODE0_POS +: 3] = code0_ff;
            nxt_prdata[addr_decode_pkg::CODE1_POS +: 3] = code1_ff;
            nxt_prdata[addr_decode_pkg::CODE2_POS +: 3] = code2_ff;
            nxt_prdata[addr_decode_pkg::CODE3_POS +: 3] = code3_ff;
         end
         addr_decode_pkg::OFS_STATUS: begin
            nxt_prdata[addr_decode_pkg::STAT_WIDE_POS] = strap_sync_ff;
            nxt_prdata[addr_decode_pkg::STAT_ORDER_POS] = codes_ordered;
         end
         addr_decode_pkg::OFS_DRAM_TOP: begin
            nxt_prdata = bank_end3;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   // sampled in the setup cycle so the access cycle sees a flop
   always_ff @(posedge clk) begin
      if (srst) begin
         prdata_ff <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata_ff <= nxt_prdata;
      end
   end

   assign prdata = prdata_ff;
   // zero wait: read data is ready by the access cycle
   assign pready = 1'b1;
   // setup never flags an error, only the access cycle
   assign pslverr = psel && penable && !mapped;

   // ************************************************
   // checks
   // ************************************************
   // dram is kept out of the whole internal block, gaps included
   logic [28:0] all_sel;
   assign all_sel = {win_hit, ext1_hit, ext0_hit, dram_bank_select_0, dram_bank_select_1,
                     dram_rom_bank_select_2, dram_rom_bank_select_3};

   property p_one_select;
      @(posedge clk) disable iff (srst) $onehot0(all_sel);
   endproperty
   a_one_select: assert property (p_one_select) else $error("more than one select active");

   property p_idle_quiet;
      !addr_valid |-> all_sel == 29'h00000000;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("select without a valid address");

   property p_bus_ctrl;
      @(posedge clk) disable iff (srst)
         (addr_valid && phys_addr[31:5] == 27'h0780000) |-> bus_control_unit_sel && !dma_address_unit_1_sel;
   endproperty
   a_bus_ctrl: assert property (p_bus_ctrl) else $error("bus control window missed");

   property p_dma_ctrl;
      @(posedge clk) disable iff (srst)
         dma_control_unit_sel |-> addr_valid && phys_addr >= 32'h0F00_0040 && phys_addr <= 32'h0F00_005F;
   endproperty
   a_dma_ctrl: assert property (p_dma_ctrl) else $error("dma control select outside its window");

   property p_sdram_win;
      @(posedge clk) disable iff (srst)
         (addr_valid && phys_addr[31:5] == 27'h0780020) |-> sdram_control_unit_sel;
   endproperty
   a_sdram_win: assert property (p_sdram_win) else $error("sdram control window missed");

   property p_gap_quiet;
      @(posedge clk) disable iff (srst)
         (phys_addr >= 32'h0F00_0200 && phys_addr <= 32'h0F00_03FF) |-> all_sel == 29'h00000000;
   endproperty
   a_gap_quiet: assert property (p_gap_quiet) else $error("reserved gap produced a select");

   property p_gap_upper;
      phys_addr[31:9] == 23'h078007 |-> all_sel == 29'h00000000;
   endproperty
   a_gap_upper: assert property (p_gap_upper) else $error("upper reserved gap produced a select");

   property p_pci_win;
      addr_valid && phys_addr[31:9] == 23'h078006 |-> pci_bridge_unit_sel;
   endproperty
   a_pci_win: assert property (p_pci_win) else $error("pci bridge window missed");

   property p_serial_win;
      serial_port_unit_sel |-> phys_addr[31:5] == 27'h0780040;
   endproperty
   a_serial_win: assert property (p_serial_win) else $error("serial port select outside its window");

   property p_led_win;
      addr_valid && phys_addr[31:5] == 27'h078000C |-> led_control_unit_sel;
   endproperty
   a_led_win: assert property (p_led_win) else $error("led window missed");

   property p_ext_io;
      @(posedge clk) disable iff (srst)
         addr_valid |-> (ext_io_select_1 == (phys_addr[31:25] == 7'h06)) && (ext_io_select_0 == (phys_addr[31:25] == 7'h05));
   endproperty
   a_ext_io: assert property (p_ext_io) else $error("external i/o select mismatch");

   property p_strap_sync;
      @(posedge clk) disable iff (srst) ##2 wide_bus_mode == $past(wide_bus_strap, 2);
   endproperty
   a_strap_sync: assert property (p_strap_sync) else $error("strap not reflected after two clocks");

   property p_bank1_place;
      @(posedge clk) disable iff (srst)
         (dram_ok && code0_ff == 3'h5 && code1_ff == 3'h4 && phys_addr >= 32'h0400_0000 && phys_addr < 32'h0600_0000)
         |-> dram_bank_select_1;
   endproperty
   a_bank1_place: assert property (p_bank1_place) else $error("bank 1 not stacked above bank 0");

   property p_expansion;
      @(posedge clk) disable iff (srst)
         dram_expansion_space |-> wide_bus_mode && (dram_rom_bank_select_2 || dram_rom_bank_select_3);
   endproperty
   a_expansion: assert property (p_expansion) else $error("expansion flag without wide bus bank 2 or 3");

   property p_narrow_flat;
      !wide_bus_mode |-> !dram_expansion_space;
   endproperty
   a_narrow_flat: assert property (p_narrow_flat) else $error("expansion space in narrow bus mode");

   property p_bank0_8mb;
      @(posedge clk) disable iff (srst)
         (dram_ok && code0_ff == 3'h2) |-> dram_bank_select_0 == (phys_addr < 32'h0080_0000);
   endproperty
   a_bank0_8mb: assert property (p_bank0_8mb) else $error("8 MB bank 0 size wrong");

   property p_bank0_64mb;
      dram_ok && code0_ff == 3'h5 |-> dram_bank_select_0 == (phys_addr < 32'h0400_0000);
   endproperty
   a_bank0_64mb: assert property (p_bank0_64mb) else $error("64 MB bank 0 size wrong");

endmodule

// >>> rtl/addr_decode_pkg.sv
// constants shared by the physical address decoder
package addr_decode_pkg;

   // ************************************************
   // internal register windows
   // ************************************************
   localparam int NUM_WIN = 23;

   localparam int IDX_BUS_CTRL = 0;
   localparam int IDX_DMA_ADDR1 = 1;
   localparam int IDX_DMA_CTRL = 2;
   localparam int IDX_CLK_MASK = 3;
   localparam int IDX_INT_CTRL1 = 4;
   localparam int IDX_INT_CTRL2 = 5;
   localparam int IDX_PWR1 = 6;
   localparam int IDX_PWR2 = 7;
   localparam int IDX_TIME1 = 8;
   localparam int IDX_TIME2 = 9;
   localparam int IDX_GPIO1 = 10;
   localparam int IDX_GPIO2 = 11;
   localparam int IDX_LED = 12;
   localparam int IDX_CSER1 = 13;
   localparam int IDX_CSER2 = 14;
   localparam int IDX_DMA_ADDR2 = 15;
   localparam int IDX_SDRAM = 16;
   localparam int IDX_SERIAL = 17;
   localparam int IDX_DBG_SERIAL = 18;
   localparam int IDX_IR1 = 19;
   localparam int IDX_IR2 = 20;
   localparam int IDX_PCI = 21;
   localparam int IDX_SYS_CTRL = 22;

   localparam logic [31:0] WIN_LO [NUM_WIN] = '{
      32'h0F00_0000, 32'h0F00_0020, 32'h0F00_0040, 32'h0F00_0060, 32'h0F00_0080, 32'h0F00_00A0,
      32'h0F00_00C0, 32'h0F00_00E0, 32'h0F00_0100, 32'h0F00_0120, 32'h0F00_0140, 32'h0F00_0160,
      32'h0F00_0180, 32'h0F00_01A0, 32'h0F00_01C0, 32'h0F00_01E0, 32'h0F00_0400, 32'h0F00_0800,
      32'h0F00_0820, 32'h0F00_0840, 32'h0F00_0860, 32'h0F00_0C00, 32'h0F00_1000};
   localparam logic [31:0] WIN_HI [NUM_WIN] = '{
      32'h0F00_001F, 32'h0F00_003F, 32'h0F00_005F, 32'h0F00_007F, 32'h0F00_009F, 32'h0F00_00BF,
      32'h0F00_00DF, 32'h0F00_00FF, 32'h0F00_011F, 32'h0F00_013F, 32'h0F00_015F, 32'h0F00_017F,
      32'h0F00_019F, 32'h0F00_01BF, 32'h0F00_01DF, 32'h0F00_01FF, 32'h0F00_041F, 32'h0F00_081F,
      32'h0F00_083F, 32'h0F00_085F, 32'h0F00_087F, 32'h0F00_0DFF, 32'h0F00_101F};
   localparam logic [31:0] INT_IO_LO = 32'h0F00_0000;
   localparam logic [31:0] INT_IO_HI = 32'h0F00_13FF;

   // ************************************************
   // external i/o windows
   // ************************************************
   localparam logic [31:0] EXT_IO1_LO = 32'h0C00_0000;
   localparam logic [31:0] EXT_IO1_HI = 32'h0DFF_FFFF;
   localparam logic [31:0] EXT_IO0_LO = 32'h0A00_0000;
   localparam logic [31:0] EXT_IO0_HI = 32'h0BFF_FFFF;

   // ************************************************
   // dram bank capacity codes
   // ************************************************
   localparam logic [2:0] CODE_8MB = 3'h2;
   localparam logic [2:0] CODE_16MB = 3'h3;
   localparam logic [2:0] CODE_32MB = 3'h4;
   localparam logic [2:0] CODE_64MB = 3'h5;
   localparam logic [31:0] CAP_8MB = 32'h0080_0000;
   localparam logic [31:0] CAP_16MB = 32'h0100_0000;
   localparam logic [31:0] CAP_32MB = 32'h0200_0000;
   localparam logic [31:0] CAP_64MB = 32'h0400_0000;
   localparam logic [31:0] DRAM_BASE = 32'h0000_0000;

   // ************************************************
   // apb register map
   // ************************************************
   localparam logic [7:0] OFS_MEM_SIZE = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_DRAM_TOP = 8'h08;
   localparam int CODE0_POS = 0;
   localparam int CODE1_POS = 4;
   localparam int CODE2_POS = 8;
   localparam int CODE3_POS = 12;
   localparam int STAT_WIDE_POS = 0;
   localparam int STAT_ORDER_POS = 1;
   localparam logic [2:0] CODE_RESET = 3'h2;

endpackage

// >>> verif/bus_master_model.sv
// partner model: processor bus master driving the decode path and the register bus
`timescale 1ns/1ps

module bus_master_model (
   input wire logic clk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   output logic addr_valid,
   output logic [31:0] phys_addr,
   output logic stalled
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      addr_valid = 1'b0;
      phys_addr = 32'h0;
      stalled = 1'b0;
   end

   // ************************************************
   // apb transfer, request held until pready is seen or 16 clocks pass
   // ************************************************
   task apb(input logic wr, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd, output logic err);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= adr;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) stalled = 1'b1;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // software never lets a higher bank exceed a lower one
   task program_codes(inout logic [2:0] c [4]);
      logic [2:0] t;
      logic [31:0] r;
      logic e;
      for (int i = 0; i < 3; i++) begin
         for (int j = 0; j < 3 - i; j++) begin
            if (c[j] < c[j + 1]) begin
               t = c[j];
               c[j] = c[j + 1];
               c[j + 1] = t;
            end
         end
      end
      apb(1'b1, 8'h00, {16'h0, 1'b0, c[3], 1'b0, c[2], 1'b0, c[1], 1'b0, c[0]}, r, e);
   endtask

   task drive(input logic v, input logic [31:0] a);
      @(posedge clk);
      addr_valid <= v;
      phys_addr <= a;
   endtask
endmodule

// >>> verif/physical_address_decoder_bench.sv
// self-checking bench for the physical address decoder
`timescale 1ns/1ps

module physical_address_decoder_bench;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic wide_bus_strap = 1'b0;
   logic wide_exp = 1'b0;
   logic psel, penable, pwrite, addr_valid, pready, pslverr, stalled, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, phys_addr, rd, base, c;
   logic wide_bus_mode;
   wire [29:0] sel_v;
   logic [2:0] codes [4];
   int errors = 0;
   int cmp_count = 0;
   int seed = 59280;
   localparam logic [31:0] EDGES [16] = '{32'h0F00_0200, 32'h0F00_03FF, 32'h0F00_0420, 32'h0F00_07FF,
      32'h0F00_0880, 32'h0F00_0BFF, 32'h0F00_0E00, 32'h0F00_0FFF, 32'h0F00_1020, 32'h0F00_13FF,
      32'h09FF_FFFF, 32'h0A00_0000, 32'h0BFF_FFFF, 32'h0C00_0000, 32'h0DFF_FFFF, 32'h0E00_0000};

   always #12.5 clk = ~clk;

   physical_address_decoder physical_address_decoder_inst (
      .clk(clk), .srst(srst), .addr_valid(addr_valid), .phys_addr(phys_addr), .wide_bus_strap(wide_bus_strap),
      .bus_control_unit_sel(sel_v[0]), .dma_address_unit_1_sel(sel_v[1]), .dma_control_unit_sel(sel_v[2]),
      .clock_mask_unit_sel(sel_v[3]), .interrupt_control_unit_1_sel(sel_v[4]),
      .interrupt_control_unit_2_sel(sel_v[5]), .power_mgmt_unit_1_sel(sel_v[6]), .power_mgmt_unit_2_sel(sel_v[7]),
      .timekeeping_unit_1_sel(sel_v[8]), .timekeeping_unit_2_sel(sel_v[9]), .general_io_unit_1_sel(sel_v[10]),
      .general_io_unit_2_sel(sel_v[11]), .led_control_unit_sel(sel_v[12]), .clocked_serial_unit_1_sel(sel_v[13]),
      .clocked_serial_unit_2_sel(sel_v[14]), .dma_address_unit_2_sel(sel_v[15]), .sdram_control_unit_sel(sel_v[16]),
      .serial_port_unit_sel(sel_v[17]), .debug_serial_unit_sel(sel_v[18]), .fast_infrared_unit_1_sel(sel_v[19]),
      .fast_infrared_unit_2_sel(sel_v[20]), .pci_bridge_unit_sel(sel_v[21]), .system_control_unit_sel(sel_v[22]),
      .ext_io_select_0(sel_v[23]), .ext_io_select_1(sel_v[24]), .dram_bank_select_0(sel_v[25]),
      .dram_bank_select_1(sel_v[26]), .dram_rom_bank_select_2(sel_v[27]), .dram_rom_bank_select_3(sel_v[28]),
      .dram_expansion_space(sel_v[29]), .wide_bus_mode(wide_bus_mode), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   bus_master_model bus_master_model_inst (
      .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .addr_valid(addr_valid), .phys_addr(phys_addr),
      .stalled(stalled));

   // ************************************************
   // expectations
   // ************************************************
   function automatic logic [31:0] cap(input logic [2:0] code);
      case (code)
         addr_decode_pkg::CODE_8MB: return addr_decode_pkg::CAP_8MB;
         addr_decode_pkg::CODE_16MB: return addr_decode_pkg::CAP_16MB;
         addr_decode_pkg::CODE_32MB: return addr_decode_pkg::CAP_32MB;
         addr_decode_pkg::CODE_64MB: return addr_decode_pkg::CAP_64MB;
         default: return 32'h0;
      endcase
   endfunction

   // i/o wins over dram, so dram is only looked for outside every i/o window
   function automatic logic [31:0] exp_sel(input logic v, input logic [31:0] a);
      logic [31:0] r, b0, cp;
      r = 32'h0;
      b0 = addr_decode_pkg::DRAM_BASE;
      if (v !== 1'b1) return r;
      for (int i = 0; i < addr_decode_pkg::NUM_WIN; i++) begin
         if (a >= addr_decode_pkg::WIN_LO[i] && a <= addr_decode_pkg::WIN_HI[i]) r[i] = 1'b1;
      end
      if (a >= addr_decode_pkg::EXT_IO0_LO && a <= addr_decode_pkg::EXT_IO0_HI) r[23] = 1'b1;
      if (a >= addr_decode_pkg::EXT_IO1_LO && a <= addr_decode_pkg::EXT_IO1_HI) r[24] = 1'b1;
      if (r != 32'h0 || (a >= 32'h0F00_0000 && a <= 32'h0F00_13FF)) return r;
      for (int b = 0; b < 4; b++) begin
         cp = cap(codes[b]);
         if (a >= b0 && a - b0 < cp) begin
            r[25 + b] = 1'b1;
            r[29] = (b > 1) && wide_exp;
         end
         b0 += cp;
      end
      return r;
   endfunction

   // ************************************************
   // shared tasks
   // ************************************************
   task check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task results;
      if (stalled === 1'b1) errors++;
      if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task rd_chk(input logic [7:0] a, input logic [31:0] e);
      bus_master_model_inst.apb(1'b0, a, 32'h0, rd, err);
      if (stalled === 1'b1) begin
         errors++;
         results();
      end
      check(rd, e);
   endtask

   task probe(input logic v, input logic [31:0] a);
      bus_master_model_inst.drive(v, a);
      @(negedge clk);
      check({2'b00, sel_v}, exp_sel(v, a));
   endtask

   initial begin
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      codes = '{3'h2, 3'h2, 3'h2, 3'h2};
      rd_chk(addr_decode_pkg::OFS_MEM_SIZE, 32'h0000_2222);
      rd_chk(addr_decode_pkg::OFS_DRAM_TOP, 32'h0200_0000);
      rd_chk(addr_decode_pkg::OFS_STATUS, 32'h0000_0002);
      bus_master_model_inst.apb(1'b1, 8'h0C, 32'h0000_5555, rd, err);
      rd_chk(8'h0C, 32'h0);
      check({31'h0, err}, 32'h1);
      rd_chk(addr_decode_pkg::OFS_MEM_SIZE, 32'h0000_2222);
      for (int i = 0; i < addr_decode_pkg::NUM_WIN; i++) begin
         probe(1'b1, addr_decode_pkg::WIN_LO[i]);
         probe(1'b1, addr_decode_pkg::WIN_HI[i]);
         probe(1'b1, addr_decode_pkg::WIN_LO[i] + $unsigned($random(seed)) %
            (addr_decode_pkg::WIN_HI[i] - addr_decode_pkg::WIN_LO[i] + 32'h1));
      end
      for (int i = 0; i < 16; i++) probe(1'b1, EDGES[i]);
      probe(1'b0, addr_decode_pkg::WIN_LO[2]);
      for (int k = 0; k < 12; k++) begin
         for (int b = 0; b < 4; b++) codes[b] = 3'($unsigned($random(seed)) % 7);
         if (k == 0) codes = '{3'h2, 3'h3, 3'h4, 3'h5};
         if (k == 1) codes = '{3'h5, 3'h5, 3'h5, 3'h5};
         @(posedge clk) wide_bus_strap <= k[0];
         bus_master_model_inst.program_codes(codes);
         repeat (3) @(posedge clk);
         wide_exp = k[0];
         check({31'h0, wide_bus_mode}, {31'h0, wide_exp});
         rd_chk(addr_decode_pkg::OFS_MEM_SIZE, {16'h0, 1'b0, codes[3], 1'b0, codes[2], 1'b0, codes[1], 1'b0, codes[0]});
         rd_chk(addr_decode_pkg::OFS_STATUS, {30'h0, 1'b1, wide_exp});
         base = 32'h0;
         for (int b = 0; b < 4; b++) begin
            c = cap(codes[b]);
            if (c != 32'h0 && base + c <= 32'h0A00_0000) begin
               probe(1'b1, base);
               probe(1'b1, base + c - 32'h1);
            end
            base += c;
         end
         rd_chk(addr_decode_pkg::OFS_DRAM_TOP, base);
         if (base < 32'h0A00_0000) probe(1'b1, base);
         probe(1'b1, $unsigned($random(seed)) % 32'h0A00_0000);
         probe(1'b1, EDGES[k]);
      end
      bus_master_model_inst.apb(1'b1, addr_decode_pkg::OFS_MEM_SIZE, 32'h0000_5432, rd, err);
      rd_chk(addr_decode_pkg::OFS_STATUS, {30'h0, 1'b0, wide_exp});
      results();
   end
endmodule
